// ### plh_defs.svh
`ifndef PLH_DEFS_SVH
`define PLH_DEFS_SVH

// Host port select codes
`define PLH_SEL_WADDR 2'h0
`define PLH_SEL_DATA 2'h1
`define PLH_SEL_RADDR 2'h3

// Table and transfer geometry
`define PLH_LUT_DEPTH 256
`define PLH_COMP_W 6
`define PLH_LAST_COMP 2'h2

// Event buffer geometry
`define PLH_FIFO_DEPTH 32
`define PLH_EV_WIDTH 10

// Idle level of the synchronised pins {sel, wr_n, rd_n, din}
`define PLH_PIN_IDLE 12'h300

`endif

// ### plh_pkg.sv
package plh_pkg;

  // Host events carried through the buffer
  typedef enum logic [1:0] {
    ev_waddr,
    ev_raddr,
    ev_wdata,
    ev_rdone
  } plh_ev_type;

  // Table engine states
  typedef enum logic {
    st_run,
    st_fetch
  } plh_state_type;

endpackage : plh_pkg

// ### plh_ev_if.sv
`timescale 1ns/100ps
`default_nettype none

interface plh_ev_if #(
  parameter int W = 10
) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : plh_ev_if

`default_nettype wire

// ### plh_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module plh_fifo
  import plh_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Filling and draining sides
  plh_ev_if.snk wr,
  plh_ev_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic [AW:0] next_wptr;
  logic [AW:0] next_rptr;
  logic full;
  logic empty;
  logic [WIDTH-1:0] mem [DEPTH];

  // Extra pointer bit tells full from empty
  assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty = (wptr == rptr);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rptr[AW-1:0]];

  // Pointer advance
  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    if (wr.valid && !full) begin
      next_wptr = wptr + (AW+1)'(1);
    end
    if (rd.ready && !empty) begin
      next_rptr = rptr + (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge mclk) begin
    if (wr.valid && !full) begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end

endmodule : plh_fifo

`default_nettype wire

// ### plh_palette_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "plh_defs.svh"

// Overview of operation
// (RULE1) Host loads write index, then writes red, green, blue bytes.
// (RULE2) After blue, assembled word is stored at index, index advances.
// (RULE3) Every three color bytes give one table write and one increment; the code drops color bytes in read mode, with no write.
// (RULE4) Host best streams consecutive entries after one index load.
// (RULE5) Loading read index fetches that entry and advances the index.
// (RULE6) Three data reads give red, green, blue; then next entry fetched.
// (RULE7) Any index load drops a partial sequence and restarts fresh.
// (RULE8) Table holds 256 entries of three 6-bit fields.
// (RULE9) Host sees the table only through an 8-bit data port.
// (RULE10) Host strobes are asynchronous and synchronised into the clock.
// (RULE11) Only low six bits stored; reads return them zero-extended.
module plh_palette_port
  import plh_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Host byte port, asynchronous
  input wire logic [1:0] host_sel,
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic [7:0] host_din,
  output logic [7:0] host_dout,
  output logic host_doe,
  output logic host_wait,
  // Pixel lookup
  input wire logic [7:0] pix_addr,
  output logic [17:0] pix_color
);

  // Pick one 6-bit component of a table word
  function automatic logic [5:0] comp_of(input logic [17:0] w,
                                         input logic [1:0] n);
    logic [5:0] c;
    c = w[5:0];
    if (n == 2'h0) begin
      c = w[17:12];
    end else if (n == 2'h1) begin
      c = w[11:6];
    end
    return c;
  endfunction : comp_of

  logic [11:0] pin_s1;
  logic [11:0] pin_s2;
  logic [11:0] pin_s3;
  logic [11:0] pin_flt;
  logic [11:0] next_flt;
  logic next_push_valid;
  logic [9:0] next_push_data;
  logic push_valid;
  logic [9:0] push_data;

  plh_ev_if #(.W(`PLH_EV_WIDTH)) in_if ();
  plh_ev_if #(.W(`PLH_EV_WIDTH)) out_if ();

  assign in_if.valid = push_valid;
  assign in_if.data = push_data;

  // Event buffer; lets slow table work lag the host
  plh_fifo #(.WIDTH(`PLH_EV_WIDTH), .DEPTH(`PLH_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(in_if),
    .rd(out_if)
  );

  // (RULE10) pin filtering
  // A bit changes only once stages two and three agree
  always_comb begin
    next_flt = (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_flt & (pin_s2 ^ pin_s3));
    next_push_valid = 1'b0;
    next_push_data = {ev_wdata, pin_flt[7:0]};
    // Data is taken at strobe release, when the bus has settled
    if (!pin_flt[9] && next_flt[9]) begin
      if (pin_flt[11:10] == `PLH_SEL_WADDR) begin
        next_push_valid = 1'b1;
        next_push_data = {ev_waddr, pin_flt[7:0]};
      end else if (pin_flt[11:10] == `PLH_SEL_RADDR) begin
        next_push_valid = 1'b1;
        next_push_data = {ev_raddr, pin_flt[7:0]};
      end else if (pin_flt[11:10] == `PLH_SEL_DATA) begin
        next_push_valid = 1'b1;
        next_push_data = {ev_wdata, pin_flt[7:0]};
      end
    end else if (!pin_flt[8] && next_flt[8] &&
                 pin_flt[11:10] == `PLH_SEL_DATA) begin
      next_push_valid = 1'b1;
      next_push_data = {ev_rdone, 8'h00};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= `PLH_PIN_IDLE;
      pin_s2 <= `PLH_PIN_IDLE;
      pin_s3 <= `PLH_PIN_IDLE;
      pin_flt <= `PLH_PIN_IDLE;
      push_valid <= 1'b0;
      push_data <= 10'h000;
    end else begin
      pin_s1 <= {host_sel, host_wr_n, host_rd_n, host_din};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_flt <= next_flt;
      push_valid <= next_push_valid;
      push_data <= next_push_data;
    end
  end

  // (RULE8) color table
  logic [17:0] lut [`PLH_LUT_DEPTH];
  logic [17:0] rd_q;
  plh_state_type state;
  plh_state_type next_state;
  logic [7:0] idx;
  logic [7:0] next_idx;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic rmode;
  logic next_rmode;
  logic [5:0] red;
  logic [5:0] next_red;
  logic [5:0] grn;
  logic [5:0] next_grn;
  logic [17:0] cval;
  logic [17:0] next_cval;
  logic lut_we;
  logic [17:0] lut_wdata;
  logic [7:0] fetch_addr;
  plh_ev_type ev;
  logic [7:0] ev_byte;
  logic [7:0] next_dout;
  logic next_doe;
  logic next_wait;

  assign ev = plh_ev_type'(out_if.data[9:8]);
  assign ev_byte = out_if.data[7:0];
  // Engine stalls the buffer while a fetch is pending
  assign out_if.ready = (state == st_run);

  // Table engine
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_cnt = cnt;
    next_rmode = rmode;
    next_red = red;
    next_grn = grn;
    next_cval = cval;
    lut_we = 1'b0;
    lut_wdata = {red, grn, ev_byte[5:0]};
    fetch_addr = idx;
    if (state == st_fetch) begin
      next_cval = rd_q;
      next_state = st_run;
    end else if (out_if.valid) begin
      case (ev)
        ev_waddr: begin
          // (RULE7) restart on index load
          next_idx = ev_byte;
          next_cnt = 2'h0;
          next_rmode = 1'b0;
        end
        ev_raddr: begin
          // (RULE5) fetch and advance
          next_rmode = 1'b1;
          next_cnt = 2'h0;
          fetch_addr = ev_byte;
          next_idx = ev_byte + 8'h01;
          next_state = st_fetch;
        end
        ev_wdata: begin
          // Bytes in read mode are dropped, no sequence to feed
          if (!rmode) begin
            // (RULE11) keep low six bits
            if (cnt == 2'h0) begin
              next_red = ev_byte[5:0];
              next_cnt = 2'h1;
            end else if (cnt == 2'h1) begin
              next_grn = ev_byte[5:0];
              next_cnt = 2'h2;
            end else begin
              // (RULE2) commit and advance
              // (RULE3) one write per triplet
              lut_we = 1'b1;
              next_idx = idx + 8'h01;
              next_cnt = 2'h0;
            end
          end
        end
        default: begin
          // (RULE6) next entry after blue
          if (rmode) begin
            if (cnt == `PLH_LAST_COMP) begin
              next_cnt = 2'h0;
              next_idx = idx + 8'h01;
              next_state = st_fetch;
            end else begin
              next_cnt = cnt + 2'h1;
            end
          end
        end
      endcase
    end
    // (RULE9) byte-wide answer
    // (RULE11) zero-extended component
    next_dout = {2'h0, comp_of(next_cval, next_cnt)};
    next_doe = !pin_flt[8] && (pin_flt[11:10] == `PLH_SEL_DATA);
    next_wait = !in_if.ready;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_run;
      idx <= 8'h00;
      cnt <= 2'h0;
      rmode <= 1'b0;
      red <= 6'h00;
      grn <= 6'h00;
      cval <= 18'h00000;
      host_dout <= 8'h00;
      host_doe <= 1'b0;
      host_wait <= 1'b0;
      pix_color <= 18'h00000;
    end else begin
      state <= next_state;
      idx <= next_idx;
      cnt <= next_cnt;
      rmode <= next_rmode;
      red <= next_red;
      grn <= next_grn;
      cval <= next_cval;
      host_dout <= next_dout;
      host_doe <= next_doe;
      host_wait <= next_wait;
      pix_color <= lut[pix_addr];
    end
  end

  // Table ports; contents are undefined until software loads them
  always_ff @(posedge mclk) begin
    if (lut_we) begin
      lut[idx] <= lut_wdata;
    end
    rd_q <= lut[fetch_addr];
  end

endmodule : plh_palette_port

`default_nettype wire

// ### plh_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host CPU stand-in on the byte port
module plh_host_model (
  // Clock and answer
  input wire logic mclk,
  input wire logic doe,
  input wire logic [7:0] dout,
  // Strobes and byte
  output logic [1:0] sel,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] din
);
  // Idle pins before reset ends
  initial begin
    sel = 2'h0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    din = 8'h00;
  end
  // Step n edges, then move off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // select, byte, strobe
  // Six cycles each side, the synchroniser needs four
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    sel = s;
    din = d;
    tick(1);
    wr_n = 1'b0;
    tick(6);
    wr_n = 1'b1;
    // Byte stays past the filtered release, then the bus lets go
    tick(4);
    din = ~d; // Released bus keeps no byte
    tick(2);
  endtask : wr
  // read strobe, byte taken before release
  task automatic rd(input logic [1:0] s, output logic [7:0] d,
                    output logic ok);
    sel = s;
    tick(5);
    rd_n = 1'b0;
    tick(8);
    d = dout;
    ok = doe;
    rd_n = 1'b1;
    tick(6);
  endtask : rd
endmodule : plh_host_model
`default_nettype wire

// ### plh_palette_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
module plh_port_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Host byte port
  input wire logic [1:0] host_sel,
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic [7:0] host_dout,
  input wire logic host_doe,
  input wire logic host_wait,
  // Pixel lookup
  input wire logic [7:0] pix_addr,
  input wire logic [17:0] pix_color
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] idle;
  // Cycles with no strobe; queued events drain well inside 24
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle <= 8'h00;
    end else if (!host_wr_n || !host_rd_n) begin
      idle <= 8'h00;
    end else if (idle != 8'hff) begin
      idle <= idle + 8'h01;
    end
  end
  sequence s_rd_go;
    $fell(host_rd_n) && host_sel == 2'h1;
  endsequence
  sequence s_quiet;
    idle > 8'h18;
  endsequence
  property p_doe_on;
    s_rd_go |-> ##[2:8] host_doe;
  endproperty
  a_doe_on: assert property (p_doe_on) else $error("doe late");
  property p_doe_off;
    $rose(host_rd_n) |-> ##[2:8] !host_doe;
  endproperty
  a_doe_off: assert property (p_doe_off) else $error("doe stuck");
  property p_zero_ext;
    host_dout[7:6] == 2'h0;
  endproperty
  a_zero_ext: assert property (p_zero_ext) else $error("dout msb");
  property p_rst_out;
    $rose(rst_n) |-> host_dout == 8'h00 && !host_doe && !host_wait;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset out");
  property p_no_sel2;
    (host_sel == 2'h2) [*8] |-> !host_doe;
  endproperty
  a_no_sel2: assert property (p_no_sel2) else $error("sel2 read");
  property p_pix_hold;
    s_quiet and $stable(pix_addr) |=> $stable(pix_color);
  endproperty
  a_pix_hold: assert property (p_pix_hold) else $error("lut moved");
  property p_dout_hold;
    s_quiet |=> $stable(host_dout);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("dout slid");
  property p_wait_idle;
    s_quiet |-> !host_wait;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait set");
endmodule : plh_port_chk
bind plh_palette_port plh_port_chk u_chk (.mclk, .rst_n, .host_sel,
  .host_wr_n, .host_rd_n, .host_dout, .host_doe, .host_wait, .pix_addr,
  .pix_color);
`default_nettype wire

// ### tb_plh_palette_port.sv
`timescale 1ns/100ps
`default_nettype none
module tb_plh_palette_port;
  logic mclk, rst_n, host_wr_n, host_rd_n, host_doe, host_wait, ok;
  logic [1:0] host_sel;
  logic [7:0] host_din, host_dout, pix_addr, a, d;
  logic [17:0] pix_color;
  logic [17:0] ref_lut [256];
  int mismatches, num_checks, seed;
  plh_palette_port dut (.mclk, .rst_n, .host_sel, .host_wr_n, .host_rd_n,
    .host_din, .host_dout, .host_doe, .host_wait, .pix_addr, .pix_color);
  plh_host_model host (.mclk, .doe(host_doe), .dout(host_dout),
    .sel(host_sel), .wr_n(host_wr_n), .rd_n(host_rd_n), .din(host_din));
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Stored word keeps six bits a byte
  function automatic logic [17:0] pack(logic [7:0] r, g, b);
    return {r[5:0], g[5:0], b[5:0]};
  endfunction : pack
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // one index load, then a stream of random triplets
  task automatic put(input logic [7:0] i, input int n);
    logic [7:0] c [3];
    host.wr(2'h0, i);
    repeat (n) begin
      for (int k = 0; k < 3; k++) begin
        c[k] = 8'($random(seed));
        host.wr(2'h1, c[k]);
      end
      ref_lut[i] = pack(c[0], c[1], c[2]);
      i++;
    end
  endtask : put
  // Look entries up on the pixel side
  task automatic pchk(input logic [7:0] i, input int n);
    repeat (n) begin
      pix_addr = i;
      repeat (2) @(posedge mclk);
      #1;
      check(pix_color, ref_lut[i]);
      i++;
    end
  endtask : pchk
  // Read n entries back, red first
  task automatic get(input logic [7:0] i, input int n);
    host.wr(2'h3, i);
    repeat (n) begin
      for (int k = 2; k >= 0; k--) begin
        host.rd(2'h1, d, ok);
        check({17'h0, ok}, 18'h1);
        check({10'h0, d}, {12'h0, ref_lut[i][6*k +: 6]});
      end
      i++;
    end
  endtask : get
  // Main sequence
  initial begin
    seed = 81;
    rst_n = 1'b0;
    pix_addr = 8'h00;
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    @(posedge mclk);
    #1;
    put(8'hfe, 6);
    pchk(8'hfe, 6);
    get(8'hfe, 5);
    // Quiet spell so the idle-time properties get exercised
    host.tick(40);
    check({17'h0, host_wait}, 18'h0);
    $display("wrap burst done");
    repeat (3) begin
      a = 8'($random(seed));
      put(a, 4);
      pchk(a, 4);
      get(a, 3);
    end
    host.tick(40);
    $display("random bursts done");
    put(8'h10, 2);
    host.wr(2'h0, 8'h10);
    host.wr(2'h1, 8'h2a);
    host.wr(2'h1, 8'h15);
    put(8'h11, 1);
    pchk(8'h10, 2);
    host.wr(2'h3, 8'hfe);
    host.rd(2'h1, d, ok);
    check({10'h0, d}, {12'h0, ref_lut[8'hfe][17:12]});
    // Color bytes in read mode leave the table alone
    repeat (3) host.wr(2'h1, 8'h3f);
    pchk(8'hff, 1);
    get(8'h00, 2);
    host.rd(2'h2, d, ok);
    check({17'h0, ok}, 18'h0);
    host.tick(40);
    $display("abort and select tests done");
    summarize();
  end
  // Watchdog, about nine times the expected run
  initial begin
    #1000000;
    mismatches++;
    summarize();
  end
endmodule : tb_plh_palette_port
`default_nettype wire
